/* File: inc/qmc_defines.svh */
// Constants of the quad mode entry and exit controller: opcodes, bit positions, counts and register indices.
`ifndef QMC_DEFINES_SVH
`define QMC_DEFINES_SVH

// =====================================================================
// Command opcodes taken from the serial link.
`define QMC_OP_RD_SR1 8'h05
`define QMC_OP_RD_SR2 8'h35
`define QMC_OP_WR_SR 8'h01
`define QMC_OP_QPI_EN 8'h38
`define QMC_OP_QPI_DIS 8'hFF
`define QMC_OP_RST_EN 8'h66
`define QMC_OP_RST 8'h99
`define QMC_OP_QIO_RD 8'hEB

// =====================================================================
// Mode byte values of the continuous quad read.
`define QMC_MODE_ENTER_HI 4'hA
`define QMC_MODE_EXIT 8'h00
`define QMC_MBR_NIBBLE 4'hF

// =====================================================================
// Field positions inside the two status registers.
`define QMC_SR1_BUSY_BIT 0
`define QMC_SR2_QE_BIT 1

// =====================================================================
// Frame counts in link clocks and bits.
`define QMC_MBR_CLKS 4'h8
`define QMC_ADDR_BITS 6'h18
`define QMC_DUMMY_CLKS 6'h04
`define QMC_BYTE_BITS 6'h08

// =====================================================================
// Register indices of the software port and the control reset value.
`define QMC_REG_SR1 4'h0
`define QMC_REG_SR2 4'h1
`define QMC_REG_MODE 4'h2
`define QMC_REG_CTRL 4'h3
`define QMC_REG_LAST_CMD 4'h4
`define QMC_CTRL_RESET 1'b0

`endif

/* File: inc/qmc_pkg.sv */
// Types of the quad mode entry and exit controller.
package qmc_pkg;

  // =====================================================================
  // Link frame states.
  typedef enum logic [3:0] {
    QMC_ST_START,
    QMC_ST_CMD,
    QMC_ST_ADDR,
    QMC_ST_MODE,
    QMC_ST_DUMMY,
    QMC_ST_WRSR,
    QMC_ST_RDSR,
    QMC_ST_DATA,
    QMC_ST_IGNORE
  } qmc_lk_state_t;

  // Kinds of events passed from the link domain to the system domain.
  typedef enum logic [1:0] {
    QMC_EV_CMD,
    QMC_EV_WRSR,
    QMC_EV_MODE,
    QMC_EV_MBR
  } qmc_ev_kind_t;

  // =====================================================================
  // Frame state on the rising link clock, cleared while chip select is high.
  typedef struct packed {
    qmc_lk_state_t st;
    logic [5:0] cnt;
    logic [7:0] sh;
    logic sel_sr2;
    logic wr_second;
    logic cont_frame;
    logic all_f;
    logic [3:0] clk_cnt;
  } qmc_lk_t;

  // Event word and its toggle, kept across frames.
  typedef struct packed {
    logic tgl;
    qmc_ev_kind_t kind;
    logic [7:0] data;
    logic busy_s1;
    logic busy_s2;
  } qmc_ev_t;

  // Output drive on the falling link clock.
  typedef struct packed {
    logic [3:0] io;
    logic [3:0] oe;
  } qmc_tx_t;

  // System clock state.
  typedef struct packed {
    logic cs_s1;
    logic cs_s2;
    logic tg_s1;
    logic tg_s2;
    logic tg_d;
    logic qe_p;
    logic qpi_p;
    logic cont_p;
    logic qe;
    logic qpi;
    logic cont;
    logic arm;
    logic busy;
    logic hold_en;
    logic wp_en;
    logic [7:0] last_cmd;
    logic [7:0] rdata;
  } qmc_mc_t;

endpackage

/* File: rtl/qmc_ctrl.sv */
// Quad mode entry and exit controller of a serial flash: link decoder, mode state and software port.
//
// What this block does
// - The quad enable bit sits at bit 1 of the second status register.
// - Opcode 05h returns the first status register on the data lines.
// - Opcode 35h returns the second status register, which holds the quad enable bit.
// - Opcode 01h with two data bytes sets or clears the quad enable bit from bit 1 of the second byte.
// - While the quad enable bit is one, the hold and write-protect pin functions are switched off.
// - A mode byte of the form Axh after the address of a quad read enters continuous quad read, only with quad enable set.
// - A mode byte of 00h during continuous quad read leaves that mode when the current read ends.
// - All ones on the four data lines for 8 clocks leaves continuous quad read before the next read.
// - Opcode 38h with quad enable set enters full quad-command mode, where commands come on four lines.
// - Opcode FFh leaves full quad-command mode and returns to single-line commands.
// - The software reset sequence also leaves full quad-command mode.
// - The software reset is opcode 66h followed by 99h, on one or four lines as the current mode sets.
// - The busy flag of the first status register reads 1 while an internal operation runs and 0 when ready.
//
// The address-and-strobe port and the placing of the registers are this design's own decisions.
`include "qmc_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module qmc_ctrl (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  output logic [3:0] io_o,
  output logic [3:0] io_oe_o,
  output logic hold_fn_en_o,
  output logic wp_fn_en_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o
);

  // =====================================================================
  // Declarations.
  qmc_pkg::qmc_lk_t lk_ff;
  qmc_pkg::qmc_lk_t nxt_lk;
  qmc_pkg::qmc_ev_t ev_ff;
  qmc_pkg::qmc_ev_t nxt_ev;
  qmc_pkg::qmc_tx_t tx_ff;
  qmc_pkg::qmc_tx_t nxt_tx;
  qmc_pkg::qmc_mc_t mc_ff;
  qmc_pkg::qmc_mc_t nxt_mc;
  logic frame_rst_n;
  logic [7:0] sr1_byte;
  logic [7:0] sr2_byte;

  // Builds a status byte with a single flag at the given position.
  function automatic logic [7:0] qmc_flag_byte(input logic flag, input int pos);
    logic [7:0] b;
    b = 8'h00;
    b[pos] = flag;
    return b;
  endfunction

  // The link frame logic is held cleared while chip select is high or the device is reset.
  // The link clock is parked between frames, so the release of this reset never races a clock edge,
  // and a frame cut short by the host cannot leave the decoder half way through a byte.
  assign frame_rst_n = nrst_i & ~cs_n_i;

  // Status bytes as the link shows them; mode bits are frozen by the system side during a frame.
  assign sr1_byte = qmc_flag_byte(ev_ff.busy_s2, `QMC_SR1_BUSY_BIT);
  assign sr2_byte = qmc_flag_byte(mc_ff.qe, `QMC_SR2_QE_BIT);

  // =====================================================================
  // Link domain: frame decoder on the rising link clock.
  // The mode bits of the system side are read here without synchronisers on purpose: they only move
  // while chip select is high, when this logic is held in reset, so they stand still for a whole frame.
  always_comb begin
    qmc_pkg::qmc_lk_state_t es;
    logic quad;
    logic [5:0] step;
    logic [7:0] sh_n;
    logic [5:0] cnt_n;
    es = lk_ff.st;
    quad = mc_ff.qpi;
    step = 6'h01;
    sh_n = 8'h00;
    cnt_n = 6'h00;
    nxt_lk = lk_ff;
    nxt_ev = ev_ff;
    // Busy is a level from the system domain and passes two flip-flops.
    nxt_ev.busy_s1 = mc_ff.busy;
    nxt_ev.busy_s2 = ev_ff.busy_s1;
    // The first clock of a frame picks opcode or address by the mode.
    if (lk_ff.st == qmc_pkg::QMC_ST_START) begin
      if (mc_ff.cont) begin
        es = qmc_pkg::QMC_ST_ADDR;
        nxt_lk.cont_frame = 1'b1;
      end else begin
        es = qmc_pkg::QMC_ST_CMD;
      end
    end
    // Address, mode and dummy phases of the quad read always use four lines.
    if (es == qmc_pkg::QMC_ST_ADDR || es == qmc_pkg::QMC_ST_MODE || es == qmc_pkg::QMC_ST_DUMMY) begin
      quad = 1'b1;
    end
    if (quad) begin
      step = 6'h04;
      sh_n = {lk_ff.sh[3:0], io_i};
    end else begin
      sh_n = {lk_ff.sh[6:0], io_i[0]};
    end
    cnt_n = lk_ff.cnt + step;
    nxt_lk.sh = sh_n;
    nxt_lk.cnt = cnt_n;
    nxt_lk.st = es;
    case (es)
      qmc_pkg::QMC_ST_CMD: begin
        // Command byte, one or four lines wide as the mode sets.
        if (cnt_n == `QMC_BYTE_BITS) begin
          nxt_lk.cnt = 6'h00;
          nxt_ev.tgl = ~ev_ff.tgl;
          nxt_ev.kind = qmc_pkg::QMC_EV_CMD;
          nxt_ev.data = sh_n;
          if (sh_n == `QMC_OP_RD_SR1) begin
            nxt_lk.st = qmc_pkg::QMC_ST_RDSR;
            nxt_lk.sel_sr2 = 1'b0;
          end else if (sh_n == `QMC_OP_RD_SR2) begin
            nxt_lk.st = qmc_pkg::QMC_ST_RDSR;
            nxt_lk.sel_sr2 = 1'b1;
          end else if (sh_n == `QMC_OP_WR_SR) begin
            nxt_lk.st = qmc_pkg::QMC_ST_WRSR;
          end else if (sh_n == `QMC_OP_QIO_RD && mc_ff.qe) begin
            nxt_lk.st = qmc_pkg::QMC_ST_ADDR;
          end else begin
            nxt_lk.st = qmc_pkg::QMC_ST_IGNORE;
          end
        end
      end
      qmc_pkg::QMC_ST_ADDR: begin
        // Twenty-four address bits in six clocks.
        if (cnt_n == `QMC_ADDR_BITS) begin
          nxt_lk.cnt = 6'h00;
          nxt_lk.st = qmc_pkg::QMC_ST_MODE;
        end
      end
      qmc_pkg::QMC_ST_MODE: begin
        // The mode byte is handed to the system side, which decides entry or exit.
        if (cnt_n == `QMC_BYTE_BITS) begin
          nxt_lk.cnt = 6'h00;
          nxt_lk.st = qmc_pkg::QMC_ST_DUMMY;
          nxt_ev.tgl = ~ev_ff.tgl;
          nxt_ev.kind = qmc_pkg::QMC_EV_MODE;
          nxt_ev.data = sh_n;
        end
      end
      qmc_pkg::QMC_ST_DUMMY: begin
        // Dummy clocks counted one per clock.
        nxt_lk.cnt = lk_ff.cnt + 6'h01;
        if (lk_ff.cnt + 6'h01 == `QMC_DUMMY_CLKS) begin
          nxt_lk.st = qmc_pkg::QMC_ST_DATA;
        end
      end
      qmc_pkg::QMC_ST_WRSR: begin
        // Two data bytes; only a complete second byte is passed on.
        if (cnt_n == `QMC_BYTE_BITS) begin
          nxt_lk.cnt = 6'h00;
          if (lk_ff.wr_second) begin
            nxt_ev.tgl = ~ev_ff.tgl;
            nxt_ev.kind = qmc_pkg::QMC_EV_WRSR;
            nxt_ev.data = sh_n;
            nxt_lk.st = qmc_pkg::QMC_ST_IGNORE;
          end else begin
            nxt_lk.wr_second = 1'b1;
          end
        end
      end
      qmc_pkg::QMC_ST_RDSR: begin
        // Bit position of the status byte being shifted out, repeating.
        nxt_lk.cnt = {3'b000, cnt_n[2:0]};
      end
      default: begin
        nxt_lk.cnt = 6'h00;
      end
    endcase
    // Mode bit reset: all ones on the four lines for the first 8 clocks of a continuous frame.
    // Its event takes the place of the mode byte event of the same clock, so one toggle carries
    // exactly one event and the all-ones mode byte is never mistaken for a plain exit.
    nxt_lk.clk_cnt = (lk_ff.clk_cnt == `QMC_MBR_CLKS) ? lk_ff.clk_cnt : lk_ff.clk_cnt + 4'h1;
    nxt_lk.all_f = (lk_ff.clk_cnt == 4'h0 ? 1'b1 : lk_ff.all_f) & (io_i == `QMC_MBR_NIBBLE);
    if (nxt_lk.cont_frame && nxt_lk.all_f && lk_ff.clk_cnt == `QMC_MBR_CLKS - 4'h1) begin
      nxt_ev.tgl = ~ev_ff.tgl;
      nxt_ev.kind = qmc_pkg::QMC_EV_MBR;
      nxt_ev.data = sh_n;
      nxt_lk.st = qmc_pkg::QMC_ST_IGNORE;
    end
  end

  // Frame state register; cleared by chip select so no clock is needed after a frame.
  always_ff @(posedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      lk_ff <= '{st: qmc_pkg::QMC_ST_START, cnt: 6'h00, sh: 8'h00, sel_sr2: 1'b0, wr_second: 1'b0,
                 cont_frame: 1'b0, all_f: 1'b0, clk_cnt: 4'h0};
    end else begin
      lk_ff <= nxt_lk;
    end
  end

  // Event word register; its toggle survives frames.
  // Kind and data are written together with the toggle and stay put for at least two link clocks,
  // far longer than the system side needs to see the toggle through its two flip-flops.
  always_ff @(posedge sclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ev_ff <= '{tgl: 1'b0, kind: qmc_pkg::QMC_EV_CMD, data: 8'h00, busy_s1: 1'b0, busy_s2: 1'b0};
    end else begin
      ev_ff <= nxt_ev;
    end
  end

  // =====================================================================
  // Link domain: status output, changed on the falling link clock.
  always_comb begin
    logic [7:0] b;
    b = lk_ff.sel_sr2 ? sr2_byte : sr1_byte;
    nxt_tx.io = 4'h0;
    nxt_tx.oe = 4'h0;
    if (lk_ff.st == qmc_pkg::QMC_ST_RDSR) begin
      if (mc_ff.qpi) begin
        nxt_tx.io = lk_ff.cnt[2] ? b[3:0] : b[7:4];
        nxt_tx.oe = 4'hF;
      end else begin
        nxt_tx.io = {2'b00, b[3'h7 - lk_ff.cnt[2:0]], 1'b0};
        nxt_tx.oe = 4'h2;
      end
    end
  end

  // Output drive register; released as soon as chip select rises.
  // Driving from the falling edge gives the host half a link clock of setup before it samples
  // on the next rising edge.
  always_ff @(negedge sclk_i or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      tx_ff <= '{io: 4'h0, oe: 4'h0};
    end else begin
      tx_ff <= nxt_tx;
    end
  end

  assign io_o = tx_ff.io;
  assign io_oe_o = tx_ff.oe;

  // =====================================================================
  // System domain: event decode, mode state and software port.
  // Besides chip select, only the toggle is synchronised; the event word is read once the toggle has crossed, when it
  // is known to be settled. Pending mode bits collect the events of a frame and move to the live
  // mode bits only once chip select has been seen high.
  always_comb begin
    logic ev_hit;
    nxt_mc = mc_ff;
    // Chip select and the event toggle each pass two flip-flops.
    nxt_mc.cs_s1 = cs_n_i;
    nxt_mc.cs_s2 = mc_ff.cs_s1;
    nxt_mc.tg_s1 = ev_ff.tgl;
    nxt_mc.tg_s2 = mc_ff.tg_s1;
    nxt_mc.tg_d = mc_ff.tg_s2;
    ev_hit = mc_ff.tg_s2 ^ mc_ff.tg_d;
    // The event word is stable for several link clocks after its toggle.
    if (ev_hit) begin
      case (ev_ff.kind)
        qmc_pkg::QMC_EV_CMD: begin
          nxt_mc.last_cmd = ev_ff.data;
          nxt_mc.arm = (ev_ff.data == `QMC_OP_RST_EN);
          if (ev_ff.data == `QMC_OP_QPI_EN && mc_ff.qe_p) begin
            nxt_mc.qpi_p = 1'b1;
          end else if (ev_ff.data == `QMC_OP_QPI_DIS) begin
            nxt_mc.qpi_p = 1'b0;
          end else if (ev_ff.data == `QMC_OP_RST && mc_ff.arm) begin
            nxt_mc.qpi_p = 1'b0;
            nxt_mc.cont_p = 1'b0;
          end
        end
        qmc_pkg::QMC_EV_WRSR: begin
          nxt_mc.qe_p = ev_ff.data[`QMC_SR2_QE_BIT];
          nxt_mc.arm = 1'b0;
        end
        qmc_pkg::QMC_EV_MODE: begin
          // Axh keeps or enters the mode; any other byte, 00h among them, ends it with the read.
          nxt_mc.cont_p = (ev_ff.data[7:4] == `QMC_MODE_ENTER_HI) && mc_ff.qe_p;
          nxt_mc.arm = 1'b0;
        end
        default: begin
          nxt_mc.cont_p = 1'b0;
          nxt_mc.arm = 1'b0;
        end
      endcase
    end
    // Modes take effect only between frames, so the link never sees them move.
    if (mc_ff.cs_s2) begin
      nxt_mc.qe = mc_ff.qe_p;
      nxt_mc.qpi = mc_ff.qpi_p;
      nxt_mc.cont = mc_ff.cont_p;
    end
    // The pin functions follow the live quad enable bit one clock later, from registers of their own.
    nxt_mc.hold_en = ~mc_ff.qe;
    nxt_mc.wp_en = ~mc_ff.qe;
    // Software write: the control register stands for a running internal operation.
    if (reg_wr_i && reg_addr_i == `QMC_REG_CTRL) begin
      nxt_mc.busy = reg_wdata_i[0];
    end
    // Software read: data stand in the following cycle only.
    nxt_mc.rdata = 8'h00;
    if (reg_rd_i) begin
      if (reg_addr_i == `QMC_REG_SR1) begin
        nxt_mc.rdata = qmc_flag_byte(mc_ff.busy, `QMC_SR1_BUSY_BIT);
      end else if (reg_addr_i == `QMC_REG_SR2) begin
        nxt_mc.rdata = qmc_flag_byte(mc_ff.qe, `QMC_SR2_QE_BIT);
      end else if (reg_addr_i == `QMC_REG_MODE) begin
        nxt_mc.rdata = {5'h00, mc_ff.cont, mc_ff.qpi, mc_ff.qe};
      end else if (reg_addr_i == `QMC_REG_CTRL) begin
        nxt_mc.rdata = {7'h00, mc_ff.busy};
      end else if (reg_addr_i == `QMC_REG_LAST_CMD) begin
        nxt_mc.rdata = mc_ff.last_cmd;
      end else begin
        nxt_mc.rdata = 8'h00;
      end
    end
  end

  // System state register.
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mc_ff <= '{cs_s1: 1'b1, cs_s2: 1'b1, tg_s1: 1'b0, tg_s2: 1'b0, tg_d: 1'b0, qe_p: 1'b0, qpi_p: 1'b0,
                 cont_p: 1'b0, qe: 1'b0, qpi: 1'b0, cont: 1'b0, arm: 1'b0, busy: `QMC_CTRL_RESET,
                 hold_en: 1'b1, wp_en: 1'b1, last_cmd: 8'h00, rdata: 8'h00};
    end else begin
      mc_ff <= nxt_mc;
    end
  end

  assign hold_fn_en_o = mc_ff.hold_en;
  assign wp_fn_en_o = mc_ff.wp_en;
  assign reg_rdata_o = mc_ff.rdata;

endmodule // qmc_ctrl

`default_nettype wire

/* File: test/qmc_ctrl_assertions.sv */
// Port checker of the quad mode entry and exit controller.
`timescale 1ns/10ps
`default_nettype none

module qmc_ctrl_assertions (
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] io_i,
  input wire logic [3:0] io_o,
  input wire logic [3:0] io_oe_o,
  input wire logic hold_fn_en_o,
  input wire logic wp_fn_en_o,
  input wire logic [3:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o
);
  // =====================================================================
  // Helper decodes of the software port.
  logic rd_sr2;
  logic rd_mode;
  assign rd_sr2 = reg_rd_i && reg_addr_i == 4'h1;
  assign rd_mode = reg_rd_i && reg_addr_i == 4'h2;

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  // =====================================================================
  // Relations between the port signals.
  AST_SR2_BITS: assert property (rd_sr2 |=> (reg_rdata_o & 8'hFD) == 8'h00) else $error("sr2 spare bits set");
  AST_SR1_BUSY: assert property (reg_wr_i && reg_addr_i == 4'h3 ##1 reg_rd_i && reg_addr_i == 4'h0
    |=> reg_rdata_o == {7'h00, $past(reg_wdata_i[0], 2)}) else $error("busy flag does not follow control");
  AST_RD_IDLE: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data outside slot");
  AST_UNMAPPED: assert property (reg_rd_i && reg_addr_i > 4'h4 |=> reg_rdata_o == 8'h00) else $error("unmapped read");
  AST_MODE_NEEDS_QE: assert property (rd_mode |=> reg_rdata_o[7:3] == 5'h00
    && (reg_rdata_o[0] || reg_rdata_o[2:1] == 2'b00)) else $error("quad mode without quad enable");
  AST_PIN_FN_PAIR: assert property (hold_fn_en_o == wp_fn_en_o) else $error("hold and wp functions differ");
  AST_PIN_FN_FRAME: assert property (!$stable(hold_fn_en_o) |-> cs_n_i) else $error("pin function change in frame");
  AST_MODE_PIN: assert property (rd_mode && $stable(hold_fn_en_o) ##1 $stable(hold_fn_en_o)
    |-> reg_rdata_o[0] == !hold_fn_en_o) else $error("quad enable and pin function disagree");
  AST_SINGLE_OE: assert property (hold_fn_en_o |-> io_oe_o inside {4'h0, 4'h2}) else $error("quad drive without qe");
  AST_CS_OE: assert property (cs_n_i && $past(cs_n_i) |-> io_oe_o == 4'h0) else $error("drive while deselected");

  // Main scenarios reached.
  COV_CONT: cover property (rd_mode ##1 reg_rdata_o[2]);
  COV_QPI: cover property (rd_mode ##1 reg_rdata_o[1]);
  COV_QE: cover property ($fell(hold_fn_en_o));
  COV_QUAD_OE: cover property (io_oe_o == 4'hF);
endmodule // qmc_ctrl_assertions

bind qmc_ctrl qmc_ctrl_assertions qmc_ctrl_assertions_i (.mclk_i, .nrst_i, .sclk_i, .cs_n_i, .io_i, .io_o, .io_oe_o,
  .hold_fn_en_o, .wp_fn_en_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);

`default_nettype wire

/* File: test/qmc_host_model.sv */
// Behavioural host controller that drives frames on the serial link.
`timescale 1ns/10ps
`default_nettype none
`include "qmc_defines.svh"

module qmc_host_model (
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] io_o,
  input wire logic [3:0] io_i
);
  // =====================================================================
  // Idle link: clock parked low, chip select high.
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    io_o = 4'h0;
  end

  // One link clock: lines set while low, sampled on the rise.
  task automatic clk(input logic [3:0] v, output logic [3:0] s);
    io_o = v;
    #62.5 sclk_o = 1'b1;
    s = io_i;
    #62.5 sclk_o = 1'b0;
  endtask

  // A byte MSB first, one line or a nibble a clock.
  task automatic put(input logic [7:0] b, input logic q);
    logic [3:0] s;
    if (q) begin
      clk(b[7:4], s);
      clk(b[3:0], s);
    end else begin
      for (int i = 7; i >= 0; i--) clk({~io_o[3:1], b[i]}, s);
    end
  endtask

  // A byte taken back while the host keeps driving the lines with toggling values.
  task automatic get(input logic q, output logic [7:0] b);
    logic [3:0] s;
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      clk(~io_o, s);
      b = q ? {b[3:0], s} : {b[6:0], s[1]};
    end
  endtask

  // Frame edges; the gap leaves time for mode changes to settle.
  task automatic frame_on();
    cs_n_o = 1'b0;
    #62.5 io_o = ~io_o;
  endtask
  task automatic frame_off();
    #62.5 cs_n_o = 1'b1;
    io_o = ~io_o;
    #200 io_o = ~io_o;
  endtask

  // Status read frames.
  task automatic rdst(input logic [7:0] op, input logic q, output logic [7:0] d);
    frame_on();
    put(op, q);
    get(q, d);
    frame_off();
  endtask

  // Single opcode frame.
  task automatic cmd(input logic [7:0] op, input logic q);
    frame_on();
    put(op, q);
    frame_off();
  endtask

  // Write status: first byte ignored, bit 1 of the second is quad enable.
  task automatic wrsr(input logic qe, input logic q);
    frame_on();
    put(`QMC_OP_WR_SR, q);
    put(8'h00, q);
    put({6'h00, qe, 1'b0}, q);
    frame_off();
  endtask

  // Quad read: opcode unless continuous, quad address, mode, dummy, data.
  task automatic qread(input logic cont, input logic q, input logic [23:0] a, input logic [7:0] m);
    logic [7:0] d;
    frame_on();
    if (!cont) put(`QMC_OP_QIO_RD, q);
    put(a[23:16], 1'b1);
    put(a[15:8], 1'b1);
    put(a[7:0], 1'b1);
    put(m, 1'b1);
    get(1'b1, d);
    get(1'b1, d);
    get(1'b1, d);
    frame_off();
  endtask

  // Mode bit reset: all ones on the four lines for 8 clocks.
  task automatic mbr();
    logic [3:0] s;
    frame_on();
    repeat (8) clk(4'hF, s);
    frame_off();
  endtask

  // Software reset: enable then reset in separate frames.
  task automatic swrst(input logic q);
    cmd(`QMC_OP_RST_EN, q);
    cmd(`QMC_OP_RST, q);
  endtask
endmodule // qmc_host_model

`default_nettype wire

/* File: test/quad_mode_entry_exit_control_tb_top.sv */
// Self-checking testbench of the quad mode entry and exit controller.
`timescale 1ns/10ps
`default_nettype none
`include "qmc_defines.svh"

module quad_mode_entry_exit_control_tb_top;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic [3:0] io_o;
  logic [3:0] io_oe_o;
  logic hold_fn_en_o;
  logic wp_fn_en_o;
  logic h_sclk;
  logic h_cs_n;
  logic [3:0] h_io;
  logic [3:0] line;
  logic [31:0] seed = 32'h00007EC7;
  int n_mismatch = 0;
  int compares = 0;

  // System clock and the merged level of the four data lines.
  always #5 mclk_i = ~mclk_i;
  assign line = (io_oe_o & io_o) | (~io_oe_o & h_io);

  qmc_ctrl qmc_ctrl_i (.mclk_i(mclk_i), .nrst_i(nrst_i), .sclk_i(h_sclk), .cs_n_i(h_cs_n), .io_i(line),
    .io_o(io_o), .io_oe_o(io_oe_o), .hold_fn_en_o(hold_fn_en_o), .wp_fn_en_o(wp_fn_en_o),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o));
  qmc_host_model h (.sclk_o(h_sclk), .cs_n_o(h_cs_n), .io_o(h_io), .io_i(line));

  // =====================================================================
  // Expectation helpers and the random source.
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] mode_v(input logic qe, input logic qpi, input logic cont);
    return {5'h00, cont, qpi, qe};
  endfunction

  // Software port cycles and comparison.
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Control write and status read back to back, so the busy flag is seen in the very next cycle.
  task automatic wrrd(input logic [7:0] d, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= 4'h3;
    reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    reg_addr_i <= 4'h0;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge mclk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask

  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog against a hung link or port.
  initial begin
    #400000 n_mismatch++;
    conclude();
  end

  // =====================================================================
  // Main sequence.
  initial begin
    logic [7:0] d;
    repeat (6) @(posedge mclk_i);
    nrst_i <= 1'b1;
    rchk(4'h0, 8'h00);
    rchk(4'h1, 8'h00);
    rchk(4'h2, mode_v(1'b0, 1'b0, 1'b0));
    rchk(4'hC, 8'h00);
    chk({7'h00, hold_fn_en_o}, 8'h01);
    $display("test 1 reset values done");
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      wrrd(seed[7:0], {7'h00, seed[0]});
      h.rdst(`QMC_OP_RD_SR1, 1'b0, d);
      chk(d, {7'h00, seed[0]});
    end
    wr(4'h3, 8'h00);
    $display("test 2 busy flag done");
    h.rdst(`QMC_OP_RD_SR2, 1'b0, d);
    chk(d, 8'h00);
    h.cmd(`QMC_OP_QPI_EN, 1'b0);
    h.qread(1'b0, 1'b0, seed[23:0], 8'hA5);
    rchk(4'h2, mode_v(1'b0, 1'b0, 1'b0));
    $display("test 3 quad enable off done");
    h.wrsr(1'b1, 1'b0);
    rchk(4'h1, 8'h02);
    h.rdst(`QMC_OP_RD_SR2, 1'b0, d);
    chk(d, 8'h02);
    chk({6'h00, hold_fn_en_o, wp_fn_en_o}, 8'h00);
    $display("test 4 quad enable set done");
    seed = xs(seed);
    h.qread(1'b0, 1'b0, seed[23:0], 8'hA5);
    rchk(4'h2, mode_v(1'b1, 1'b0, 1'b1));
    h.qread(1'b1, 1'b0, seed[31:8], {4'hA, seed[27:24]});
    rchk(4'h2, mode_v(1'b1, 1'b0, 1'b1));
    h.qread(1'b1, 1'b0, seed[23:0], `QMC_MODE_EXIT);
    rchk(4'h2, mode_v(1'b1, 1'b0, 1'b0));
    h.qread(1'b0, 1'b0, seed[27:4], {4'hA, seed[31:28]});
    rchk(4'h2, mode_v(1'b1, 1'b0, 1'b1));
    h.mbr();
    rchk(4'h2, mode_v(1'b1, 1'b0, 1'b0));
    h.rdst(`QMC_OP_RD_SR2, 1'b0, d);
    chk(d, 8'h02);
    $display("test 5 continuous read done");
    h.cmd(`QMC_OP_QPI_EN, 1'b0);
    rchk(4'h2, mode_v(1'b1, 1'b1, 1'b0));
    wr(4'h3, 8'h01);
    h.rdst(`QMC_OP_RD_SR1, 1'b1, d);
    chk(d, 8'h01);
    wr(4'h3, 8'h00);
    h.cmd(`QMC_OP_QPI_DIS, 1'b1);
    rchk(4'h2, mode_v(1'b1, 1'b0, 1'b0));
    rchk(4'h4, `QMC_OP_QPI_DIS);
    h.cmd(`QMC_OP_QPI_EN, 1'b0);
    h.cmd(`QMC_OP_RST_EN, 1'b1);
    h.cmd(`QMC_OP_QPI_EN, 1'b1);
    h.cmd(`QMC_OP_RST, 1'b1);
    rchk(4'h2, mode_v(1'b1, 1'b1, 1'b0));
    h.swrst(1'b1);
    rchk(4'h2, mode_v(1'b1, 1'b0, 1'b0));
    h.wrsr(1'b0, 1'b0);
    rchk(4'h2, mode_v(1'b0, 1'b0, 1'b0));
    chk({7'h00, hold_fn_en_o}, 8'h01);
    $display("test 6 quad command mode done");
    conclude();
  end
endmodule // quad_mode_entry_exit_control_tb_top

`default_nettype wire
